// ==== core/pmsl_buf.sv ====
// Two-entry buffer between the record formatter and the USB writer
module pmsl_buf (
  input wire logic clock,
  input wire logic reset,
  input wire pmsl_pkg::pmsl_log_word_t in_data,
  input wire logic in_valid,
  output logic in_ready,
  output pmsl_pkg::pmsl_log_word_t out_data,
  output logic out_valid,
  input wire logic out_ready
);

  pmsl_pkg::pmsl_log_word_t spare_reg;
  logic spare_valid_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Head feeds the output; spare holds a word taken while the head stalls
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      out_data <= '0;
      out_valid <= 1'b0;
      spare_reg <= '0;
      spare_valid_reg <= 1'b0;
      in_ready <= 1'b1;
    end
    else
    begin
      if (!out_valid || pop)
      begin
        out_valid <= spare_valid_reg || push;
        out_data <= spare_valid_reg ? spare_reg : in_data;
        spare_valid_reg <= spare_valid_reg && push;
        spare_reg <= in_data;
        in_ready <= 1'b1;
      end
      else if (push)
      begin
        spare_reg <= in_data;
        spare_valid_reg <= 1'b1;
        in_ready <= 1'b0; // Both slots full: stall the formatter
      end
    end
  end

endmodule

// ==== core/pmsl_mem.sv ====
// Snapshot store for the measurement words of one record
module pmsl_mem (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [3:0] rd_addr,
  output logic [15:0] rd_data
);

  logic [15:0] mem [0:15];

  // Registered read, one cycle of latency
  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// ==== core/pmsl_top.sv ====
// Status word, output type, comm settings, lamps and log record formatter
module pmsl_top #(
  parameter int BLINK_CYCLES = pmsl_pkg::BLINK_CYCLES,
  parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001 // Arbitrary value
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire pmsl_pkg::pmsl_faults_t FAULTS,
  input wire pmsl_pkg::pmsl_rtc_t RTC,
  input wire logic RTC_SEC_TICK,
  input wire pmsl_pkg::pmsl_meas_t MEAS,
  input wire logic [7:0] DIP_SWITCH,
  input wire logic RS485_RX_LINE,
  input wire logic RS485_TX_LINE,
  input wire logic NV_LOAD,
  input wire logic [7:0] NV_ADDR,
  input wire logic [5:0] NV_COMM,
  input wire logic CFG_WR,
  input wire logic [15:0] CFG_WDATA,
  input wire logic [15:0] HREG_ADDR,
  input wire logic HREG_WR,
  input wire logic HREG_RD,
  input wire logic [15:0] HREG_WDATA,
  output logic [15:0] HREG_RDATA,
  output logic HREG_ACK,
  output pmsl_pkg::pmsl_log_word_t LOG_WORD,
  output logic LOG_VALID,
  input wire logic LOG_READY,
  output logic [7:0] MODBUS_ADDR,
  output pmsl_pkg::pmsl_baud_t BAUD_CODE,
  output logic [1:0] PARITY,
  output logic STOP_TWO,
  output logic [15:0] OUTPUT_TYPE,
  output logic [15:0] MACHINE_STATE,
  output logic LED_FAIL,
  output logic LED_RX,
  output logic LED_TX,
  output logic LED_DOUT
);

  // ****************************************************************
  // Status word
  // ****************************************************************
  wire any_fail = FAULTS.measurement_chain_fault || FAULTS.log_fault ||
                  FAULTS.rtc_fault || FAULTS.nvm_fault;
  wire [15:0] state_next = {6'h00,
                            FAULTS.nvm_fault, FAULTS.rtc_fault, FAULTS.log_fault,
                            FAULTS.measurement_chain_fault,
                            FAULTS.dout_state, 1'b0,
                            FAULTS.under_range_fault, FAULTS.over_range,
                            FAULTS.alarm, any_fail};

  // ****************************************************************
  // Holding register decode
  // ****************************************************************
  wire wr_ot = HREG_WR && (HREG_ADDR == pmsl_pkg::HR_OUT_TYPE);
  wire wr_int = HREG_WR && (HREG_ADDR == pmsl_pkg::HR_LOG_INTERVAL);
  wire wr_addr = HREG_WR && (HREG_ADDR == pmsl_pkg::HR_MODBUS_ADDR);
  wire wr_comm = HREG_WR && (HREG_ADDR == pmsl_pkg::HR_COMM);

  logic [15:0] out_type_reg;
  logic [15:0] interval_reg;
  logic [7:0] addr_store_reg;
  logic [5:0] comm_store_reg;

  // USB configuration wins a same-cycle clash with the serial write
  wire [15:0] out_type_next = CFG_WR ? (CFG_WDATA & pmsl_pkg::OT_WRITE_MASK) :
                              wr_ot ? (HREG_WDATA & pmsl_pkg::OT_WRITE_MASK) :
                              out_type_reg;
  wire [15:0] rd_mux =
    (HREG_ADDR == pmsl_pkg::HR_STATE) ? MACHINE_STATE :
    (HREG_ADDR == pmsl_pkg::HR_OUT_TYPE) ? out_type_reg :
    (HREG_ADDR == pmsl_pkg::HR_LOG_INTERVAL) ? interval_reg :
    (HREG_ADDR == pmsl_pkg::HR_MODBUS_ADDR) ? {8'h00, addr_store_reg} :
    (HREG_ADDR == pmsl_pkg::HR_COMM) ? {10'h000, comm_store_reg} :
    16'h0000; // Unmapped reads as zero

  // Configuration registers
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      out_type_reg <= pmsl_pkg::OT_RESET;
      interval_reg <= pmsl_pkg::INTERVAL_RESET;
      addr_store_reg <= pmsl_pkg::ADDR_RESET;
      comm_store_reg <= pmsl_pkg::COMM_RESET;
    end
    else
    begin
      out_type_reg <= out_type_next;
      if (wr_int)
        interval_reg <= HREG_WDATA;
      if (wr_addr)
        addr_store_reg <= HREG_WDATA[7:0];
      else if (NV_LOAD)
        addr_store_reg <= NV_ADDR;
      if (wr_comm)
        comm_store_reg <= HREG_WDATA[5:0];
      else if (NV_LOAD)
        comm_store_reg <= NV_COMM;
    end
  end

  // Bus answer and visible state, one cycle after the strobe
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      HREG_RDATA <= 16'h0000;
      HREG_ACK <= 1'b0;
      MACHINE_STATE <= 16'h0000;
      OUTPUT_TYPE <= pmsl_pkg::OT_RESET;
    end
    else
    begin
      HREG_ACK <= HREG_RD || HREG_WR;
      if (HREG_RD)
        HREG_RDATA <= rd_mux;
      MACHINE_STATE <= state_next;
      OUTPUT_TYPE <= out_type_next;
    end
  end

  // ****************************************************************
  // Switch synchroniser and address/baud source
  // ****************************************************************
  logic [7:0] dip_meta_reg;
  logic [7:0] dip_reg;

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      dip_meta_reg <= 8'h00;
      dip_reg <= 8'h00;
    end
    else
    begin
      dip_meta_reg <= DIP_SWITCH;
      dip_reg <= dip_meta_reg;
    end
  end

  // Switches give only four common rates; the rest need stored settings
  wire sw_zero = (dip_reg == 8'h00);
  wire [5:0] sw_addr = (dip_reg[5:0] > pmsl_pkg::SW_ADDR_MAX) ?
                       pmsl_pkg::SW_ADDR_MAX : dip_reg[5:0];
  wire pmsl_pkg::pmsl_baud_t sw_baud =
    (dip_reg[7:6] == 2'h0) ? pmsl_pkg::BAUD_9600 :
    (dip_reg[7:6] == 2'h1) ? pmsl_pkg::BAUD_19200 :
    (dip_reg[7:6] == 2'h2) ? pmsl_pkg::BAUD_38400 :
    pmsl_pkg::BAUD_115200;
  wire pmsl_pkg::pmsl_baud_t nv_baud = pmsl_pkg::pmsl_baud_t'(comm_store_reg[2:0]);

  // Effective link settings
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      MODBUS_ADDR <= pmsl_pkg::ADDR_RESET;
      BAUD_CODE <= pmsl_pkg::BAUD_9600;
      PARITY <= 2'h0;
      STOP_TWO <= 1'b0;
    end
    else
    begin
      MODBUS_ADDR <= sw_zero ? addr_store_reg : {2'h0, sw_addr};
      BAUD_CODE <= sw_zero ? nv_baud : sw_baud;
      PARITY <= comm_store_reg[4:3];
      STOP_TWO <= comm_store_reg[5];
    end
  end

  // ****************************************************************
  // Indicators
  // ****************************************************************
  wire [6:0] fail_src = {FAULTS.alarm, FAULTS.nvm_fault, FAULTS.rtc_fault,
                         FAULTS.log_fault, FAULTS.measurement_chain_fault,
                         FAULTS.over_range, FAULTS.under_range_fault};
  wire [6:0] fail_en = out_type_reg[pmsl_pkg::OT_FAULT_MSB:pmsl_pkg::OT_FAULT_LSB];
  wire [1:0] line_in = {RS485_TX_LINE, RS485_RX_LINE};
  logic [1:0] act_led;
  logic [23:0] blink_cnt_reg;
  logic blink_phase_reg;

  // Shared blink divider keeps both lamps in step
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      blink_cnt_reg <= 24'h000000;
      blink_phase_reg <= 1'b0;
    end
    else if (blink_cnt_reg == 24'(BLINK_CYCLES - 1))
    begin
      blink_cnt_reg <= 24'h000000;
      blink_phase_reg <= !blink_phase_reg;
    end
    else
      blink_cnt_reg <= blink_cnt_reg + 24'h000001;
  end

  // Per line: sync, edge detect, retriggered activity window
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_line
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    logic [24:0] hold_reg;
    always_ff @(posedge CLOCK or posedge RESET)
    begin
      if (RESET)
      begin
        meta_reg <= 1'b1;
        sync_reg <= 1'b1;
        prev_reg <= 1'b1;
        hold_reg <= 25'h0000000;
      end
      else
      begin
        meta_reg <= line_in[ch];
        sync_reg <= meta_reg;
        prev_reg <= sync_reg;
        if (sync_reg != prev_reg)
          hold_reg <= 25'(2 * BLINK_CYCLES);
        else if (hold_reg != 25'h0000000)
          hold_reg <= hold_reg - 25'h0000001;
      end
    end
    assign act_led[ch] = (hold_reg != 25'h0000000) && blink_phase_reg;
  end

  // Lamp registers
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      LED_FAIL <= 1'b0;
      LED_RX <= 1'b0;
      LED_TX <= 1'b0;
      LED_DOUT <= 1'b0;
    end
    else
    begin
      LED_FAIL <= |(fail_src & fail_en);
      LED_RX <= act_led[0];
      LED_TX <= act_led[1];
      LED_DOUT <= FAULTS.dout_state;
    end
  end

  // ****************************************************************
  // Log interval timer
  // ****************************************************************
  logic [15:0] sec_cnt_reg;
  logic trig_pend_reg;
  wire interval_hit = RTC_SEC_TICK && (interval_reg != 16'h0000) &&
                      (sec_cnt_reg + 16'h0001 >= interval_reg);

  // ****************************************************************
  // Record formatter
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CAPT = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_PUSH = 4'b1000
  } pmsl_fmt_state_t;

  pmsl_fmt_state_t state_reg;
  pmsl_fmt_state_t state_next_w;
  logic [4:0] idx_reg;
  pmsl_pkg::pmsl_rtc_t stamp_reg;
  logic [15:0] rec_state_reg;
  logic [15:0] rec_type_reg;
  logic [15:0] mem_rdata;
  logic buf_ready;
  pmsl_pkg::pmsl_log_word_t push_word;

  wire [3:0] cap_idx = idx_reg[3:0];
  wire [3:0] meas_rd = 4'(idx_reg - pmsl_pkg::IDX_MEAS);
  wire push_valid = (state_reg == ST_PUSH);
  wire push_done = push_valid && buf_ready;
  wire last_word = (idx_reg == pmsl_pkg::IDX_OUT_TYPE);

  // Word selection in record order
  assign push_word.last = last_word;
  assign push_word.data =
    (idx_reg == 5'h00) ? SERIAL_NUMBER[31:16] :
    (idx_reg == 5'h01) ? SERIAL_NUMBER[15:0] :
    (idx_reg == 5'h02) ? stamp_reg.year :
    (idx_reg == 5'h03) ? {8'h00, stamp_reg.month} :
    (idx_reg == 5'h04) ? {8'h00, stamp_reg.day} :
    (idx_reg == 5'h05) ? {8'h00, stamp_reg.hour} :
    (idx_reg == 5'h06) ? {8'h00, stamp_reg.minute} :
    (idx_reg == 5'h07) ? {8'h00, stamp_reg.second} :
    (idx_reg == pmsl_pkg::IDX_STATUS) ? rec_state_reg :
    last_word ? rec_type_reg : mem_rdata;

  // Next state
  always_comb
  begin
    state_next_w = state_reg;
    case (state_reg)
      ST_IDLE:
        if (trig_pend_reg)
          state_next_w = ST_CAPT;
      ST_CAPT:
        if (cap_idx == pmsl_pkg::MEAS_LAST)
          state_next_w = ST_FETCH;
      ST_FETCH:
        state_next_w = ST_PUSH;
      ST_PUSH:
        if (push_done)
          state_next_w = last_word ? ST_IDLE : ST_FETCH;
      default:
        state_next_w = ST_IDLE;
    endcase
  end

  // Sequencer registers; a tick during a record leaves the request pending
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      state_reg <= ST_IDLE;
      idx_reg <= 5'h00;
      sec_cnt_reg <= 16'h0000;
      trig_pend_reg <= 1'b0;
      stamp_reg <= '0;
      rec_state_reg <= 16'h0000;
      rec_type_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next_w;
      if (interval_reg == 16'h0000 || interval_hit)
        sec_cnt_reg <= 16'h0000;
      else if (RTC_SEC_TICK)
        sec_cnt_reg <= sec_cnt_reg + 16'h0001;
      if (interval_hit)
        trig_pend_reg <= 1'b1; // Set wins over the clear below
      else if (state_reg == ST_IDLE)
        trig_pend_reg <= 1'b0;
      if (state_reg == ST_IDLE)
      begin
        idx_reg <= 5'h00;
        stamp_reg <= RTC;
        rec_state_reg <= MACHINE_STATE;
        rec_type_reg <= out_type_reg;
      end
      else if (state_reg == ST_CAPT)
        idx_reg <= (cap_idx == pmsl_pkg::MEAS_LAST) ? 5'h00 : idx_reg + 5'h01;
      else if (push_done)
        idx_reg <= idx_reg + 5'h01;
    end
  end

  pmsl_mem u_mem (
    .clock(CLOCK),
    .wr_en(state_reg == ST_CAPT),
    .wr_addr(cap_idx),
    .wr_data(MEAS[cap_idx]),
    .rd_addr(meas_rd),
    .rd_data(mem_rdata)
  );

  pmsl_buf u_buf (
    .clock(CLOCK),
    .reset(RESET),
    .in_data(push_word),
    .in_valid(push_valid),
    .in_ready(buf_ready),
    .out_data(LOG_WORD),
    .out_valid(LOG_VALID),
    .out_ready(LOG_READY)
  );

endmodule

// ==== shared/pmsl_pkg.sv ====
// Shared constants and types of the power meter status logger
// Operation
// - Stamp each record with calendar date and time
// - Serial number is first record field
// - Record status equals machine state register
// - Status bits 0-3: fail, alarm, over, under
// - Bit 5 output state; 6-9 individual failures
// - Measurements follow in the fixed field order
// - Output type: mode bit and quantity code
// - Output type bits 5-11 select fault sources
// - Threshold mode bits 12-13, manual bit 14
// - Output type follows USB or RS485 writes
// - All switches zero selects stored address and baud
// - Switches reach address 62 and few bauds
// - Holding register writes change address and baud when all switches are zero
// - Fail lamp shows any enabled active failure
// - Receive and transmit lamps blink on traffic
// - Output lamp follows the digital output
// - Baud 1200-115200, parity, one or two stops
// - Log interval from 1 s to about 18 h
package pmsl_pkg;

  // ****************************************************************
  // Holding register map
  // ****************************************************************
  localparam logic [15:0] HR_STATE = 16'h9c45;
  localparam logic [15:0] HR_OUT_TYPE = 16'h9c46;
  localparam logic [15:0] HR_LOG_INTERVAL = 16'h9c47;
  localparam logic [15:0] HR_MODBUS_ADDR = 16'h9c48;
  localparam logic [15:0] HR_COMM = 16'h9c49;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int OT_FAULT_LSB = 5;
  localparam int OT_FAULT_MSB = 11;
  localparam logic [15:0] OT_WRITE_MASK = 16'h7fff;
  localparam logic [15:0] OT_RESET = 16'h0000;
  localparam logic [15:0] INTERVAL_RESET = 16'h0000;
  localparam logic [7:0] ADDR_RESET = 8'h01;
  localparam logic [5:0] COMM_RESET = 6'h03;
  localparam logic [5:0] SW_ADDR_MAX = 6'h3e;

  // ****************************************************************
  // Record layout
  // ****************************************************************
  localparam logic [4:0] IDX_STATUS = 5'h08;
  localparam logic [4:0] IDX_MEAS = 5'h09;
  localparam logic [4:0] IDX_OUT_TYPE = 5'h16;
  localparam logic [3:0] MEAS_LAST = 4'hc;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLOCK_KHZ = 100000;
  localparam int BLINK_MS = 50;
  localparam int BLINK_CYCLES = BLINK_MS * CLOCK_KHZ;

  // Serial line settings
  typedef enum logic [2:0] {
    BAUD_1200 = 3'h0, BAUD_2400 = 3'h1, BAUD_4800 = 3'h2, BAUD_9600 = 3'h3,
    BAUD_19200 = 3'h4, BAUD_38400 = 3'h5, BAUD_57600 = 3'h6, BAUD_115200 = 3'h7
  } pmsl_baud_t;

  typedef struct packed {
    logic alarm;
    logic over_range;
    logic under_range_fault;
    logic dout_state;
    logic measurement_chain_fault;
    logic log_fault;
    logic rtc_fault;
    logic nvm_fault;
  } pmsl_faults_t;

  typedef struct packed {
    logic [15:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } pmsl_rtc_t;

  // Peak V, peak I, RMS V, RMS I, P, Q, S, PF, freq, E tot, E+, E-, out value
  typedef logic [12:0][15:0] pmsl_meas_t;

  typedef struct packed {
    logic last;
    logic [15:0] data;
  } pmsl_log_word_t;

endpackage

// ==== verification/pmsl_top_assertions.sv ====
// Port-level concurrent checks of the status logger
module pmsl_chk #(
  parameter int BLINK_CYCLES = 8
) (
  input CLOCK,
  input RESET,
  input pmsl_pkg::pmsl_faults_t FAULTS,
  input [7:0] DIP_SWITCH,
  input RS485_RX_LINE,
  input CFG_WR,
  input [15:0] CFG_WDATA,
  input HREG_WR,
  input HREG_RD,
  input [15:0] HREG_RDATA,
  input HREG_ACK,
  input pmsl_pkg::pmsl_log_word_t LOG_WORD,
  input LOG_VALID,
  input LOG_READY,
  input [7:0] MODBUS_ADDR,
  input pmsl_pkg::pmsl_baud_t BAUD_CODE,
  input [15:0] OUTPUT_TYPE,
  input [15:0] MACHINE_STATE,
  input LED_FAIL,
  input LED_RX,
  input LED_DOUT
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  // Expected values; fault bits run from alarm (7) down to nvm (0)
  wire pmsl_pkg::pmsl_faults_t f = FAULTS;
  wire logic [15:0] st_exp = {6'h00, f[0], f[1], f[2], f[3], f[4], 1'b0, f[5], f[6], f[7], |f[3:0]};
  wire logic fail_exp = |({f[7], f[0], f[1], f[2], f[3], f[6], f[5]} & OUTPUT_TYPE[11:5]);
  wire logic [5:0] sw_addr = (DIP_SWITCH[5:0] > 6'h3e) ? 6'h3e : DIP_SWITCH[5:0];
  wire logic [2:0] sw_baud = (DIP_SWITCH[7:6] == 2'h3) ? 3'h7 : {1'b0, DIP_SWITCH[7:6]} + 3'h3;
  logic [7:0] quiet_reg;
  // Cycles since the receive line moved, saturating
  always_ff @(posedge CLOCK or posedge RESET)
    if (RESET)
      quiet_reg <= 8'h00;
    else if ($changed(RS485_RX_LINE))
      quiet_reg <= 8'h00;
    else if (quiet_reg != 8'hff)
      quiet_reg <= quiet_reg + 8'h01;
  // ********
  // Properties
  // ********
  property p_ack;
    !$past(RESET) |-> HREG_ACK == $past(HREG_RD || HREG_WR);
  endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_rd_hold;
    !HREG_RD |=> $stable(HREG_RDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  property p_state;
    !$past(RESET) |-> MACHINE_STATE == $past(st_exp);
  endproperty
  a_state: assert property (p_state) else $error("status");
  property p_undef;
    MACHINE_STATE[4] == 1'b0 && MACHINE_STATE[15:10] == 6'h00 && OUTPUT_TYPE[15] == 1'b0;
  endproperty
  a_undef: assert property (p_undef) else $error("undef bit");
  property p_cfg;
    CFG_WR |=> OUTPUT_TYPE == ($past(CFG_WDATA) & 16'h7fff);
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg write");
  property p_fail;
    ($stable(FAULTS) && $stable(OUTPUT_TYPE)) [*3] |-> LED_FAIL == fail_exp;
  endproperty
  a_fail: assert property (p_fail) else $error("fail lamp");
  property p_dout;
    $stable(FAULTS.dout_state) [*3] |-> LED_DOUT == FAULTS.dout_state;
  endproperty
  a_dout: assert property (p_dout) else $error("dout lamp");
  property p_log_hold;
    LOG_VALID && !LOG_READY |=> LOG_VALID && $stable(LOG_WORD);
  endproperty
  a_log_hold: assert property (p_log_hold) else $error("log stall");
  property p_switch;
    ($stable(DIP_SWITCH) && DIP_SWITCH != 8'h00) [*6] |-> MODBUS_ADDR == {2'h0, sw_addr} && BAUD_CODE == sw_baud;
  endproperty
  a_switch: assert property (p_switch) else $error("switches");
  property p_quiet;
    quiet_reg > 8'(2 * BLINK_CYCLES + 6) |-> !LED_RX;
  endproperty
  a_quiet: assert property (p_quiet) else $error("rx lamp idle");
endmodule
bind pmsl_top pmsl_chk #(.BLINK_CYCLES(BLINK_CYCLES)) u_chk (.CLOCK, .RESET, .FAULTS, .DIP_SWITCH,
  .RS485_RX_LINE, .CFG_WR, .CFG_WDATA, .HREG_WR, .HREG_RD, .HREG_RDATA, .HREG_ACK, .LOG_WORD, .LOG_VALID,
  .LOG_READY, .MODBUS_ADDR, .BAUD_CODE, .OUTPUT_TYPE, .MACHINE_STATE, .LED_FAIL, .LED_RX, .LED_DOUT);

// ==== verification/pmsl_usb_model.sv ====
// Behavioural USB stick that stores log words and stalls at random
module pmsl_usb_model (
  input clock,
  input reset,
  input pmsl_pkg::pmsl_log_word_t word,
  input valid,
  input hold,
  output logic ready,
  output pmsl_pkg::pmsl_log_word_t got [32],
  output int n_got
);
  timeunit 1ns;
  timeprecision 1ps;
  // Random stalls; hold forces a long one
  always @(posedge clock or posedge reset)
    if (reset)
    begin
      ready <= 1'b0;
      n_got <= 0;
    end
    else
    begin
      ready <= !hold && ($urandom % 3 != 0);
      if (valid && ready && n_got < 32)
      begin
        got[n_got] <= word;
        n_got <= n_got + 1;
      end
    end
endmodule

// ==== verification/power_meter_status_logger_tb_top.sv ====
// Self-checking bench of the status logger
module power_meter_status_logger_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SER = 32'h5a3c_0f61; // Arbitrary serial number
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic tick = 1'b0, rx = 1'b1, tx = 1'b1, nv_load = 1'b0, cfg_wr = 1'b0, hwr = 1'b0, hrd = 1'b0, hold = 1'b1;
  logic [7:0] dip = 8'h00, nv_addr = 8'h00;
  logic [5:0] nv_comm = 6'h00;
  logic [15:0] cfg_wdata = 16'h0000, haddr = 16'h0000, hwdata = 16'h0000;
  pmsl_pkg::pmsl_faults_t faults = 8'h00;
  pmsl_pkg::pmsl_rtc_t rtc = '0;
  pmsl_pkg::pmsl_meas_t meas = '0;
  logic [15:0] hreg_rdata, output_type;
  logic hreg_ack, log_valid, log_ready, stop_two, led_fail, led_rx, led_tx, led_dout;
  logic [7:0] modbus_addr;
  logic [1:0] parity;
  pmsl_pkg::pmsl_baud_t baud_code;
  pmsl_pkg::pmsl_log_word_t log_word;
  pmsl_pkg::pmsl_log_word_t got [32];
  int n_got;
  int n_fail = 0;
  int check_count = 0;
  pmsl_top #(.BLINK_CYCLES(8), .SERIAL_NUMBER(SER)) dut (.CLOCK(clock), .RESET(reset), .FAULTS(faults), .RTC(rtc),
    .RTC_SEC_TICK(tick), .MEAS(meas), .DIP_SWITCH(dip), .RS485_RX_LINE(rx), .RS485_TX_LINE(tx), .NV_LOAD(nv_load),
    .NV_ADDR(nv_addr), .NV_COMM(nv_comm), .CFG_WR(cfg_wr), .CFG_WDATA(cfg_wdata), .HREG_ADDR(haddr), .HREG_WR(hwr),
    .HREG_RD(hrd), .HREG_WDATA(hwdata), .HREG_RDATA(hreg_rdata), .HREG_ACK(hreg_ack), .LOG_WORD(log_word),
    .LOG_VALID(log_valid), .LOG_READY(log_ready), .MODBUS_ADDR(modbus_addr), .BAUD_CODE(baud_code),
    .PARITY(parity), .STOP_TWO(stop_two), .OUTPUT_TYPE(output_type), .MACHINE_STATE(),
    .LED_FAIL(led_fail), .LED_RX(led_rx), .LED_TX(led_tx), .LED_DOUT(led_dout));
  pmsl_usb_model usb (.clock(clock), .reset(reset), .word(log_word), .valid(log_valid), .hold(hold),
    .ready(log_ready), .got(got), .n_got(n_got));
  // Free-running 100 MHz clock
  always #5 clock = ~clock;
  // ********
  // Tasks and expectations
  // ********
  task automatic chk(input logic [16:0] g, input logic [16:0] e, input string m);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Register access; data taken with the ack
  task automatic hreg(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] r);
    @(posedge clock);
    haddr <= a;
    hwdata <= d;
    hwr <= w;
    hrd <= !w;
    @(posedge clock);
    hwr <= 1'b0;
    hrd <= 1'b0;
    #1;
    chk(17'(hreg_ack), 17'h00001, "ack");
    r = hreg_rdata;
  endtask
  task automatic cfg(input logic [15:0] d);
    @(posedge clock);
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clock);
    cfg_wr <= 1'b0;
  endtask
  // Fault bits run from alarm (7) down to nvm (0)
  function automatic logic [15:0] f_state(input pmsl_pkg::pmsl_faults_t f);
    f_state = {6'h00, f[0], f[1], f[2], f[3], f[4], 1'b0, f[5], f[6], f[7], |f[3:0]};
  endfunction
  function automatic logic f_fail(input pmsl_pkg::pmsl_faults_t f, input logic [15:0] ot);
    f_fail = |({f[7], f[0], f[1], f[2], f[3], f[6], f[5]} & ot[11:5]);
  endfunction
  // Expected address and baud
  function automatic logic [10:0] f_sw(input logic [7:0] d, input logic [7:0] sa, input logic [2:0] sb);
    logic [2:0] bt [4] = '{3'h3, 3'h4, 3'h5, 3'h7};
    f_sw = (d == 8'h00) ? {sa, sb} : {2'h0, (d[5:0] > 6'h3e) ? 6'h3e : d[5:0], bt[d[7:6]]};
  endfunction
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    logic [15:0] r, ot;
    logic [7:0] sa;
    logic [5:0] sc;
    logic [1:0] seen;
    logic [16:0] exp_w [23];
    logic [15:0] rst_tab [5] = '{16'h0000, 16'h0000, 16'h0001, 16'h0003, 16'h0000};
    logic [7:0] dtab [8] = '{8'h00, 8'h3e, 8'h3f, 8'h41, 8'h82, 8'hc5, 8'h00, 8'h17};
    void'($urandom(61));
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk({log_valid, output_type}, 17'h00000, "rst out");
    chk({3'h0, modbus_addr, baud_code, parity, stop_two}, {3'h0, 8'h01, 3'h3, 3'h0}, "rst set");
    for (int i = 0; i < 5; i++)
    begin
      if (i == 4)
        hreg(1'b1, 16'h9c4a, 16'hffff, r);
      hreg(1'b0, 16'h9c46 + 16'(i), 16'h0000, r);
      chk(17'(r), 17'(rst_tab[i]), "rst rd");
    end
    $display("test reset done");
    // Faults and type by both paths, all-ones first
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clock);
      faults <= (i == 0) ? 8'hff : 8'($urandom);
      ot = (i == 0) ? 16'hffff : 16'($urandom);
      if (i[0])
        hreg(1'b1, pmsl_pkg::HR_OUT_TYPE, ot, r);
      else
        cfg(ot);
      ot = ot & 16'h7fff;
      hreg(1'b1, pmsl_pkg::HR_STATE, ~ot, r);
      hreg(1'b0, pmsl_pkg::HR_STATE, 16'h0000, r);
      chk(17'(r), 17'(f_state(faults)), "state");
      hreg(1'b0, pmsl_pkg::HR_OUT_TYPE, 16'h0000, r);
      chk(17'(r), 17'(ot), "type");
      chk({15'h0, led_fail, led_dout}, {15'h0, f_fail(faults, ot), faults.dout_state}, "lamps");
    end
    @(posedge clock);
    haddr <= pmsl_pkg::HR_OUT_TYPE;
    hwdata <= 16'h4321;
    hwr <= 1'b1;
    cfg_wdata <= 16'h1234;
    cfg_wr <= 1'b1;
    @(posedge clock);
    hwr <= 1'b0;
    cfg_wr <= 1'b0;
    #1;
    chk(17'(output_type), 17'h01234, "cfg wins");
    $display("test status done");
    hreg(1'b1, pmsl_pkg::HR_MODBUS_ADDR, 16'h00c8, r);
    hreg(1'b1, pmsl_pkg::HR_COMM, 16'h003e, r);
    sa = 8'hc8;
    sc = 6'h3e;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock);
      dip <= dtab[i];
      nv_addr <= 8'($urandom);
      nv_comm <= 6'($urandom);
      nv_load <= (i == 6);
      @(posedge clock);
      nv_load <= 1'b0;
      if (i == 6)
        {sa, sc} = {nv_addr, nv_comm};
      repeat (6) @(posedge clock);
      #1;
      chk({6'h0, modbus_addr, baud_code}, {6'h0, f_sw(dip, sa, sc[2:0])}, "set");
      chk({14'h0, parity, stop_two}, {14'h0, sc[4:3], sc[5]}, "format");
    end
    $display("test settings done");
    seen = 2'b00;
    for (int i = 0; i < 24; i++)
    begin
      @(posedge clock);
      rx <= i[1];
      tx <= i[2];
      #1;
      seen = seen | {led_tx, led_rx};
    end
    chk(17'(seen), 17'h00003, "blink");
    repeat (40) @(posedge clock);
    #1;
    chk({15'h0, led_tx, led_rx}, 17'h00000, "idle");
    $display("test lamps done");
    // One record, stick stalled first to fill the buffer
    @(posedge clock);
    for (int k = 0; k < 13; k++)
      meas[k] <= 16'($urandom);
    rtc <= 56'({$urandom, $urandom});
    faults <= 8'($urandom);
    hreg(1'b1, pmsl_pkg::HR_LOG_INTERVAL, 16'h0001, r);
    @(posedge clock);
    tick <= 1'b1;
    @(posedge clock);
    tick <= 1'b0;
    repeat (60) @(posedge clock);
    hold <= 1'b0;
    for (int t = 0; t < 2000 && n_got < 23; t++)
      @(posedge clock);
    exp_w[0] = {1'b0, SER[31:16]};
    exp_w[1] = {1'b0, SER[15:0]};
    exp_w[2] = {1'b0, rtc.year};
    for (int k = 0; k < 5; k++)
      exp_w[3 + k] = {9'h0, rtc[39 - 8 * k -: 8]};
    exp_w[8] = {1'b0, f_state(faults)};
    for (int k = 0; k < 13; k++)
      exp_w[9 + k] = {1'b0, meas[k]};
    exp_w[22] = {1'b1, 16'h1234};
    if (n_got < 23)
    begin
      n_fail++;
      $display("CHECK FAILED %0t record timeout", $time);
    end
    else
    begin
      for (int k = 0; k < 23; k++)
        chk(got[k], exp_w[k], "word");
      hreg(1'b1, pmsl_pkg::HR_LOG_INTERVAL, 16'h0000, r);
      @(posedge clock);
      tick <= 1'b1;
      @(posedge clock);
      tick <= 1'b0;
      repeat (100) @(posedge clock);
      chk(17'(n_got), 17'h00017, "int off");
    end
    $display("test record done");
    give_verdict();
  end
endmodule
